// File: vrcs_pkg.sv
/*
 voice recorder control sequencer: shared constants, command codes,
 state enumeration and carrier structs.
 assumes a 40 MHz clock and a 16-bit serial memory word address.
*/
// ----------------------------------------------------------------
// Overview of operation
// - stand-alone sample tick divides clock by 768 (rate low) or 512 (high).
// - select level high means record, low means playback; set before begin.
// - begin pulse starts recording, stop ends it, channel end ends it too.
// - activity flag is high exactly while recording or playback runs.
// - playback ends at recorded length or on stop, even unrecorded channel.
// - begin held low repeats playback, only with a single serial memory.
// - pause pulse suspends, begin resumes, stop terminates.
// - resume after pause skips the voice wait and records at once.
// - voice select high: begin waits for voice; stop in wait goes standby.
// - fixed mode re-recording always starts at the channel's own base.
// - flex mode starts past previous channel stop, runs to max address.
// - chip enable low passes strobes; high ignores them, data pins float.
// - latch strobe captures a nibble; fetch strobe drives status or data.
// - codes 0..5: idle, pause, playback, capture, start, stop.
// - stop in capture mode stores address counter as channel stop.
// - codes 6 and 7 take one data nibble: rate/mode, channel/mode.
// - code 8 takes eight nibbles as channel start and stop address.
// - code 9 returns eight address nibbles; status unreadable meanwhile.
// - code 10 moves data to serial memory; code 11 streams via host bus.
// - code 12 takes one nibble: voice start condition and bit length.
// - four-bit status readable by fetch strobe; busy during reset, commands.
// ----------------------------------------------------------------
package vrcs_pkg;
   localparam int ADDR_W = 16;
   localparam int CLK_MHZ = 40;
   localparam int DIV_W = 11;
   localparam logic [DIV_W-1:0] DIV_1024 = 11'h400;
   localparam logic [DIV_W-1:0] DIV_768 = 11'h300;
   localparam logic [DIV_W-1:0] DIV_640 = 11'h280;
   localparam logic [DIV_W-1:0] DIV_512 = 11'h200;
   localparam int BUSY_W = 14;
   localparam int BUSY_CMD_US = 16;
   localparam int BUSY_INDEX_US = 50;
   localparam int BUSY_RESET_US = 125;
   localparam int BUSY_CMD_CYC = BUSY_CMD_US * CLK_MHZ;
   localparam int BUSY_INDEX_CYC = BUSY_INDEX_US * CLK_MHZ;
   localparam int BUSY_RESET_CYC = BUSY_RESET_US * CLK_MHZ;
   // command codes
   localparam logic [3:0] IDLE_CODE = 4'h0;
   localparam logic [3:0] PAUSE_CMD = 4'h1;
   localparam logic [3:0] PLAYBACK_CMD = 4'h2;
   localparam logic [3:0] CAPTURE_VOICE_CMD = 4'h3;
   localparam logic [3:0] START_CMD = 4'h4;
   localparam logic [3:0] STOP_CMD = 4'h5;
   localparam logic [3:0] RATE_CONFIG_CMD = 4'h6;
   localparam logic [3:0] TRACK_CONFIG_CMD = 4'h7;
   localparam logic [3:0] INDEX_WRITE_CMD = 4'h8;
   localparam logic [3:0] INDEX_READ_CMD = 4'h9;
   localparam logic [3:0] RAW_TRANSFER_CMD = 4'ha;
   localparam logic [3:0] HOST_STREAM_CMD = 4'hb;
   localparam logic [3:0] VOICE_SELECT_CMD = 4'hc;
   localparam logic [3:0] INDEX_NIBBLES = 4'h8;
   localparam logic [3:0] ONE_NIBBLE = 4'h1;
   // word count select encodings
   localparam logic [1:0] WC_FOUR = 2'h1;
   localparam logic [1:0] WC_TWO = 2'h2;
   localparam logic [1:0] WC_FLEX = 2'h3;
   // avalon register byte offsets and control bits
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_ADDR = 4'h8;
   localparam int CTRL_HOST_MODE = 0;
   localparam int CTRL_SINGLE_MEM = 1;
   // status nibble bit positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_RUN = 1;
   localparam int STAT_WAIT = 2;
   localparam int STAT_FULL = 3;

   typedef enum logic [1:0] {
      SEQ_IDLE, SEQ_VOICE_WAIT, SEQ_RUN, SEQ_PAUSED
   } vrcs_state_t;

   // stand-alone pins, all asynchronous to the clock
   typedef struct packed {
      logic beginPulseIn_n;
      logic stopStrobe_n;
      logic pauseStrobe_n;
      logic recordPlaybackSelect;
      logic rateSelectPin;
      logic voiceTriggerSelect;
      logic wordCountSelectHigh;
      logic wordCountSelectLow;
      logic [2:0] channelSelect;
      logic voiceDetected;
   } vrcs_pins_t;

   // host nibble bus strobes and data pins in
   typedef struct packed {
      logic chipEnable_n;
      logic nibbleLatch_n;
      logic statusFetch_n;
      logic [3:0] dataIn;
   } vrcs_hbus_t;

   // serial memory / codec side
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic sampleTick;
      logic write;
      logic [3:0] writeData;
   } vrcs_mem_t;
endpackage

// File: vrcs_top.sv
/*
 voice recorder control sequencer: stand-alone pin control, host nibble
 command interpreter, channel index and address sequencing, avalon slave.
 assumes pins and host strobes are asynchronous and a codec supplies one
 adpcm nibble per sample tick.
*/
`timescale 1ns/1ps
module vrcs_top #(
   parameter int RESET_BUSY_CYC = vrcs_pkg::BUSY_RESET_CYC,
   parameter logic [vrcs_pkg::ADDR_W-1:0] VOICE_BASE = 16'h0000
) (
   input wire logic clock,
   input wire logic rst_n,
   input vrcs_pkg::vrcs_pins_t pins,
   input vrcs_pkg::vrcs_hbus_t hostBus,
   output logic [3:0] dataOut,
   output logic dataOe_n,
   input wire logic [3:0] codecNibble,
   input wire logic [3:0] streamIn,
   output logic [3:0] streamNibble,
   output logic streamStrobe,
   output vrcs_pkg::vrcs_mem_t mem,
   output logic activityFlagOut,
   output logic [3:0] statusNibble,
   output logic adpcmBitLength,
   output logic [1:0] voiceCondition,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import vrcs_pkg::*;

   localparam int PW = $bits(vrcs_pins_t);
   localparam int SW = PW + $bits(vrcs_hbus_t);
   localparam int AW = ADDR_W;
   localparam int CW = AW - 3;
   // strobe bit positions inside the synchronised host bus word
   localparam int HB_FETCH = 4;
   localparam int HB_LATCH = HB_FETCH + 1;

   typedef struct packed {
      logic [SW-1:0] s1, s2, s3, stab, prev;
      logic [1:0] ctrl;
      logic ack;
      logic [31:0] rdata;
      vrcs_state_t st;
      logic isRecord;
      logic [2:0] curCh;
      logic [AW-1:0] addr, limit;
      logic [7:0][AW-1:0] startA, stopA;
      logic [DIV_W-1:0] div;
      logic [BUSY_W-1:0] busy;
      logic [3:0] pend, pcmd, readCnt;
      logic [31:0] shift;
      logic [1:0] sa, csel;
      logic rcon, recMode, bitLen, full, stream;
      logic [1:0] vd;
      logic [2:0] track_config_cmd;
      logic [3:0] dout;
      logic oeN, strm;
      logic [3:0] strmData;
      vrcs_mem_t mem;
   } vrcs_regs_t;

   vrcs_regs_t q, d;
   vrcs_pins_t pn;
   vrcs_hbus_t hb;
   logic [SW-1:0] fell, rose;
   logic host, wrEv, rdDone, startEv, stopEv, pauseEv, tick, doEnd;
   logic direct, flex, vtEn, recSel, lastNib;
   logic [1:0] wc, rateSel;
   logic [2:0] ch, mask;
   logic [3:0] nib, stat;
   logic [DIV_W-1:0] divN;
   logic [AW-1:0] recStart, recLimit;

   always_comb begin
      d = q;
      // ------------------------------------------------------------
      // input synchronisers
      // ------------------------------------------------------------
      d.s1 = {pins, hostBus};
      d.s2 = q.s1;
      d.s3 = q.s2;
      // accept a level once the second and third stages agree
      d.stab = (q.s2 & q.s3) | (q.stab & (q.s2 ^ q.s3));
      d.prev = q.stab;
      fell = q.prev & ~q.stab;
      rose = ~q.prev & q.stab;
      pn = vrcs_pins_t'(q.stab[SW-1 -: PW]);
      hb = vrcs_hbus_t'(q.stab[SW-PW-1:0]);
      host = q.ctrl[CTRL_HOST_MODE];
      nib = hb.dataIn;

      // ------------------------------------------------------------
      // effective configuration
      // ------------------------------------------------------------
      wc = host ? q.csel : {pn.wordCountSelectHigh, pn.wordCountSelectLow};
      ch = host ? q.track_config_cmd : pn.channelSelect;
      direct = host & ~q.rcon;
      flex = (wc == WC_FLEX) & ~direct;
      vtEn = host ? (q.vd != 2'h0) : pn.voiceTriggerSelect;
      recSel = host ? q.recMode : pn.recordPlaybackSelect;
      rateSel = host ? q.sa : {pn.rateSelectPin, 1'b1};
      unique case (rateSel)
         2'h0: divN = DIV_1024;
         2'h1: divN = DIV_768;
         2'h2: divN = DIV_640;
         2'h3: divN = DIV_512;
      endcase
      unique case (wc)
         WC_FOUR: mask = 3'h6;
         WC_TWO: mask = 3'h4;
         default: mask = 3'h7;
      endcase
      recStart = {ch & mask, {CW{1'b0}}};
      recLimit = {(ch & mask) | ~mask, {CW{1'b1}}};
      if (flex) begin
         recStart = (ch == 3'h0) ? VOICE_BASE
            : AW'(q.stopA[ch - 3'h1] + 1'b1);
         recLimit = '1;
      end
      if (direct) begin
         recStart = q.startA[ch];
         recLimit = q.stopA[ch];
      end

      // ------------------------------------------------------------
      // sample tick divider
      // ------------------------------------------------------------
      tick = (q.div >= divN - 1'b1);
      d.div = tick ? '0 : DIV_W'(q.div + 1'b1);
      d.mem.sampleTick = tick;
      d.mem.write = 1'b0;
      d.strm = 1'b0;
      if (q.busy != '0) begin
         d.busy = BUSY_W'(q.busy - 1'b1);
      end

      // ------------------------------------------------------------
      // event sources
      // ------------------------------------------------------------
      // strobes pass only with chip enable low
      wrEv = host & ~hb.chipEnable_n & fell[HB_LATCH];
      rdDone = host & ~hb.chipEnable_n & rose[HB_FETCH];
      startEv = ~host & fell[SW-1];
      stopEv = ~host & fell[SW-2];
      pauseEv = ~host & fell[SW-3];
      lastNib = (q.pend == ONE_NIBBLE);

      // ------------------------------------------------------------
      // host command interpreter
      // ------------------------------------------------------------
      // latch strobe captures nibble
      if (wrEv && q.strm == 1'b0 && q.stream) begin
         // host stream writes go to the codec, not the memory
         d.strmData = nib;
         d.strm = 1'b1;
      end else if (wrEv && q.pend != 4'h0) begin
         d.pend = q.pend - 1'b1;
         d.busy = BUSY_W'(BUSY_CMD_CYC);
         unique case (q.pcmd)
            RATE_CONFIG_CMD: {d.csel, d.sa} = nib;
            TRACK_CONFIG_CMD: {d.rcon, d.track_config_cmd} = nib;
            VOICE_SELECT_CMD: {d.bitLen, d.vd} = nib[2:0];
            RAW_TRANSFER_CMD: begin
               // raw write at the address counter
               d.mem.write = 1'b1;
               d.mem.writeData = nib;
               d.addr = AW'(q.addr + 1'b1);
            end
            default: begin
               // eight nibbles, start low first then stop
               d.shift = {nib, q.shift[31:4]};
               d.busy = BUSY_W'(BUSY_INDEX_CYC);
               if (lastNib) begin
                  d.startA[ch] = d.shift[AW-1:0];
                  d.stopA[ch] = d.shift[31 -: AW];
               end
            end
         endcase
      end else if (wrEv) begin
         d.busy = BUSY_W'(BUSY_CMD_CYC);
         d.pcmd = nib;
         unique case (nib)
            IDLE_CODE: ;
            PAUSE_CMD: pauseEv = 1'b1;
            PLAYBACK_CMD: begin
               d.recMode = 1'b0;
               d.full = 1'b0;
            end
            CAPTURE_VOICE_CMD: begin
               d.recMode = 1'b1;
               d.full = 1'b0;
            end
            START_CMD: begin
               startEv = 1'b1;
               d.full = 1'b0;
            end
            STOP_CMD: stopEv = 1'b1;
            RATE_CONFIG_CMD, TRACK_CONFIG_CMD, VOICE_SELECT_CMD,
            RAW_TRANSFER_CMD: d.pend = ONE_NIBBLE;
            INDEX_WRITE_CMD: begin
               d.pend = INDEX_NIBBLES;
               d.busy = BUSY_W'(BUSY_INDEX_CYC);
            end
            INDEX_READ_CMD: begin
               d.readCnt = INDEX_NIBBLES;
               d.shift = {q.stopA[ch], q.startA[ch]};
            end
            HOST_STREAM_CMD: begin
               d.stream = 1'b1;
               startEv = 1'b1;
            end
            default: ;
         endcase
      end
      if (rdDone && q.readCnt != 4'h0) begin
         d.readCnt = q.readCnt - 1'b1;
         d.shift = {4'h0, q.shift[31:4]};
      end

      // ------------------------------------------------------------
      // record / playback sequencer
      // ------------------------------------------------------------
      doEnd = 1'b0;
      unique case (q.st)
         SEQ_IDLE: begin
            if (startEv) begin
               d.isRecord = recSel;
               d.curCh = ch;
               if (recSel) begin
                  // begin starts capture at the channel start
                  d.addr = recStart;
                  d.limit = recLimit;
                  d.startA[ch] = recStart;
                  d.st = (vtEn & ~q.stream) ? SEQ_VOICE_WAIT : SEQ_RUN;
               end else begin
                  d.addr = q.startA[ch];
                  d.limit = q.stopA[ch];
                  d.st = SEQ_RUN;
               end
            end
         end
         SEQ_VOICE_WAIT: begin
            if (stopEv) begin
               d.st = SEQ_IDLE;
            end else if (pn.voiceDetected) begin
               d.st = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            if (stopEv) begin
               doEnd = 1'b1;
            end else if (pauseEv) begin
               d.st = SEQ_PAUSED;
            end else if (tick) begin
               if (q.isRecord && !q.stream) begin
                  d.mem.write = 1'b1;
                  d.mem.writeData = codecNibble;
               end
               if (q.addr == q.limit) begin
                  // repeat while begin held, single memory only
                  if (!q.isRecord && !host && !pn.beginPulseIn_n
                        && q.ctrl[CTRL_SINGLE_MEM]) begin
                     d.addr = q.startA[q.curCh];
                  end else begin
                     doEnd = 1'b1;
                     d.full = q.isRecord & flex;
                  end
               end else begin
                  d.addr = AW'(q.addr + 1'b1);
               end
            end
         end
         SEQ_PAUSED: begin
            // resume or terminate; no voice wait on resume
            if (stopEv) begin
               doEnd = 1'b1;
            end else if (startEv) begin
               d.st = SEQ_RUN;
            end
         end
      endcase
      if (doEnd) begin
         // capture stop stores the address counter
         if (q.isRecord && !q.stream) begin
            d.stopA[q.curCh] = q.addr;
         end
         d.st = SEQ_IDLE;
         d.stream = 1'b0;
      end
      d.mem.addr = d.addr;

      // ------------------------------------------------------------
      // status and data pins
      // ------------------------------------------------------------
      // busy covers reset and command processing
      stat = '0;
      stat[STAT_BUSY] = (q.busy != '0);
      stat[STAT_RUN] = (q.st == SEQ_RUN);
      stat[STAT_WAIT] = (q.st == SEQ_VOICE_WAIT) | (q.st == SEQ_PAUSED);
      stat[STAT_FULL] = q.full;
      // status hidden during index read and host stream
      if (q.readCnt != 4'h0) begin
         d.dout = q.shift[3:0];
      end else if (q.stream) begin
         d.dout = streamIn;
      end else begin
         d.dout = stat;
      end
      // data pins float unless enabled and fetched
      d.oeN = ~(host & ~hb.chipEnable_n & ~hb.statusFetch_n);

      // ------------------------------------------------------------
      // avalon slave: one wait state per access
      // ------------------------------------------------------------
      d.ack = (avs_read | avs_write) & ~q.ack;
      if ((avs_read | avs_write) && !q.ack) begin
         unique case (avs_address)
            REG_CTRL: d.rdata = {30'h0, q.ctrl};
            REG_STATUS: d.rdata = {21'h0, q.curCh, q.st, q.full,
               q.stream, stat};
            REG_ADDR: d.rdata = {16'h0, q.addr};
            default: d.rdata = '0;
         endcase
      end
      if (avs_write && q.ack && avs_address == REG_CTRL) begin
         d.ctrl = avs_writedata[1:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         // pins idle high so the release cannot fake a falling strobe
         q.s1 <= '1;
         q.s2 <= '1;
         q.s3 <= '1;
         q.stab <= '1;
         q.prev <= '1;
         q.oeN <= 1'b1;
         q.busy <= BUSY_W'(RESET_BUSY_CYC);
      end else begin
         q <= d;
      end
   end

   // activity flag tracks the run state
   assign activityFlagOut = (q.st == SEQ_RUN);
   assign dataOut = q.dout;
   assign dataOe_n = q.oeN;
   assign statusNibble = {q.full,
      (q.st == SEQ_VOICE_WAIT) | (q.st == SEQ_PAUSED),
      (q.st == SEQ_RUN), (q.busy != '0)};
   assign streamNibble = q.strmData;
   assign streamStrobe = q.strm;
   assign mem = q.mem;
   assign adpcmBitLength = q.bitLen;
   assign voiceCondition = q.vd;
   assign avs_readdata = q.rdata;
   assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
endmodule // vrcs_top

// File: vrcs_top_props.sv
/*
 checker: port timing of the control sequencer.
 assumes a bind onto vrcs_top and stand-alone pins quiet in host mode.
*/
`timescale 1ns/1ps
module vrcs_top_props #(
   parameter int RESET_BUSY_CYC = 20
) (
   input wire logic clock,
   input wire logic rst_n,
   input vrcs_pkg::vrcs_pins_t pins,
   input vrcs_pkg::vrcs_hbus_t hostBus,
   input wire logic dataOe_n,
   input vrcs_pkg::vrcs_mem_t mem,
   input wire logic activityFlagOut,
   input wire logic [3:0] statusNibble
);
   import vrcs_pkg::*;
   logic [9:0] tickGap_q;
   logic armed_q;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // tick spacing helper
   // ----------------------------------------------------------------
   // armed only inside one run, so a restart never looks like a short gap
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tickGap_q <= 10'h0;
         armed_q <= 1'b0;
      end else begin
         if (mem.sampleTick)
            tickGap_q <= 10'h0;
         else if (tickGap_q != 10'h3ff)
            tickGap_q <= tickGap_q + 10'h1;
         armed_q <= activityFlagOut && (armed_q || mem.sampleTick);
      end
   end
   a_tick_spacing:
   assert property (mem.sampleTick && armed_q |-> tickGap_q >= 10'h1ff)
      else $error("sample ticks closer than 512 clocks");
   a_run_flags:
   assert property (!(activityFlagOut && statusNibble[STAT_WAIT]))
      else $error("activity high while waiting or paused");
   a_reset_busy:
   assert property ($rose(rst_n) |-> statusNibble[STAT_BUSY] [*8])
      else $error("busy not held after reset");
   a_ce_float:
   assert property (hostBus.chipEnable_n [*6] |-> dataOe_n)
      else $error("data pins driven with chip enable high");
   a_latch_busy:
   assert property ($fell(hostBus.nibbleLatch_n) && !hostBus.chipEnable_n
      && !statusNibble[STAT_BUSY] |-> ##[3:8] statusNibble[STAT_BUSY])
      else $error("busy not raised after a nibble");
   a_begin_runs:
   assert property ($fell(pins.beginPulseIn_n) && pins.recordPlaybackSelect
      && !pins.voiceTriggerSelect && !statusNibble[STAT_BUSY]
      && !activityFlagOut |-> ##[1:10] activityFlagOut)
      else $error("begin pulse did not start recording");
   a_stop_ends:
   assert property ($fell(pins.stopStrobe_n) && activityFlagOut
      |-> ##[1:10] !activityFlagOut)
      else $error("stop pulse did not end the run");
   a_pause_holds:
   assert property ($fell(pins.pauseStrobe_n) && activityFlagOut
      |-> ##[1:10] (statusNibble[STAT_WAIT] && !activityFlagOut))
      else $error("pause pulse did not suspend");
   a_voice_waits:
   assert property ($fell(pins.beginPulseIn_n) && pins.recordPlaybackSelect
      && pins.voiceTriggerSelect && !pins.voiceDetected
      && !statusNibble[STAT_BUSY] && !statusNibble[STAT_WAIT]
      && !activityFlagOut
      |-> ##[1:10] (statusNibble[STAT_WAIT] && !activityFlagOut))
      else $error("voice triggered begin did not wait");
endmodule // vrcs_top_props

bind vrcs_top vrcs_top_props #(.RESET_BUSY_CYC(RESET_BUSY_CYC)) u_props (
   .clock(clock), .rst_n(rst_n), .pins(pins), .hostBus(hostBus),
   .dataOe_n(dataOe_n), .mem(mem), .activityFlagOut(activityFlagOut),
   .statusNibble(statusNibble));

// File: vrcs_host_model.sv
/*
 partner: host microcontroller on the strobed nibble bus.
 assumes the bench has set host mode before any nibble is sent.
*/
`timescale 1ns/1ps
module vrcs_host_model (
   input wire logic clock,
   output vrcs_pkg::vrcs_hbus_t hostBus,
   input wire logic [3:0] dataOut,
   input wire logic dataOe_n
);
   import vrcs_pkg::*;
   logic ceOff;
   initial begin
      ceOff = 1'b0;
      hostBus = {3'b111, 4'ha};
   end
   task automatic fetch(output logic [3:0] v, output logic oe);
      @(posedge clock);
      hostBus.chipEnable_n <= ceOff;
      hostBus.statusFetch_n <= 1'b0;
      repeat (8) @(posedge clock);
      @(negedge clock);
      // a floating bus has no pull: show the inverse of the last value
      v = dataOe_n ? ~dataOut : dataOut;
      oe = dataOe_n;
      @(posedge clock);
      hostBus.statusFetch_n <= 1'b1;
      repeat (8) @(posedge clock);
   endtask
   task automatic put(input logic [3:0] n);
      logic [3:0] v;
      logic oe;
      // no local limit: the bench watchdog ends a hang
      do fetch(v, oe); while (v[STAT_BUSY] !== 1'b0);
      hostBus.dataIn <= n;
      hostBus.nibbleLatch_n <= 1'b0;
      repeat (6) @(posedge clock);
      hostBus.nibbleLatch_n <= 1'b1;
      repeat (3) @(posedge clock);
      // no pull-ups on the data pins, so the old value must not linger
      hostBus.dataIn <= ~n;
   endtask
endmodule // vrcs_host_model

// File: vrcs_top_tb.sv
/*
 testbench: stand-alone pins, avalon access and host nibble commands.
 assumes the checker is bound by its own file and the host model partner.
*/
`timescale 1ns/1ps
module vrcs_top_tb;
   import vrcs_pkg::*;
   localparam int BEG = 11;
   localparam int STP = 10;
   localparam int PAU = 9;
   localparam logic [31:0] IDX = 32'h5678_1234;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   vrcs_pins_t pins;
   vrcs_hbus_t hostBus;
   vrcs_mem_t mem;
   logic [3:0] dataOut, statusNibble, avs_address, v;
   logic dataOe_n, activityFlagOut, avs_read, avs_write, avs_waitrequest, oe;
   logic adpcmBitLength;
   logic [1:0] voiceCondition;
   logic [31:0] avs_writedata, avs_readdata, q;
   int fail_count = 0;
   int n_compared = 0;

   always #12.5 clock = ~clock;

   vrcs_top #(.RESET_BUSY_CYC(20)) uut (
      .clock(clock), .rst_n(rst_n), .pins(pins), .hostBus(hostBus),
      .dataOut(dataOut), .dataOe_n(dataOe_n), .codecNibble(4'h3),
      .streamIn(4'h0), .streamNibble(), .streamStrobe(), .mem(mem),
      .activityFlagOut(activityFlagOut), .statusNibble(statusNibble),
      .adpcmBitLength(adpcmBitLength), .voiceCondition(voiceCondition),
      .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   vrcs_host_model host (.clock(clock), .hostBus(hostBus),
      .dataOut(dataOut), .dataOe_n(dataOe_n));

   task automatic chk(input string n, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // waitrequest and read data are taken at the rising edge itself
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic pulse(input int b);
      @(posedge clock);
      pins[b] <= 1'b0;
      repeat (6) @(posedge clock);
      pins[b] <= 1'b1;
      repeat (12) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic waitact(input logic e);
      int k;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (activityFlagOut !== e && k < 40);
      chk("activity", activityFlagOut, e);
   endtask
   task automatic period(input int e);
      int c;
      c = 0;
      do @(negedge clock); while (mem.sampleTick !== 1'b1 && ++c < 2000);
      c = 0;
      do begin
         @(negedge clock);
         c++;
      end while (mem.sampleTick !== 1'b1 && c < 2000);
      chk("tick_period", c, e);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_avalon;
      av(1'b1, 4'hc, 32'hffff_ffff);
      av(1'b0, 4'hc, 32'h0);
      chk("unmapped", q, 32'h0);
      av(1'b0, REG_STATUS, 32'h0);
      chk("status_busy", q[STAT_BUSY], 1'b0);
      $display("test avalon done");
   endtask
   task automatic t_rate;
      pins.rateSelectPin <= 1'b0;
      pulse(BEG);
      waitact(1'b1);
      period(768);
      pulse(STP);
      waitact(1'b0);
      @(posedge clock) pins.rateSelectPin <= 1'b1;
      pulse(BEG);
      waitact(1'b1);
      period(512);
      pulse(STP);
      waitact(1'b0);
      $display("test rate done");
   endtask
   task automatic t_voice;
      @(posedge clock) pins.voiceTriggerSelect <= 1'b1;
      pulse(BEG);
      chk("voice_wait", statusNibble[STAT_WAIT], 1'b1);
      chk("wait_idle", activityFlagOut, 1'b0);
      pulse(STP);
      chk("standby", statusNibble[STAT_WAIT], 1'b0);
      pulse(BEG);
      @(posedge clock) pins.voiceDetected <= 1'b1;
      waitact(1'b1);
      @(posedge clock) pins.voiceDetected <= 1'b0;
      pulse(PAU);
      chk("paused", statusNibble[STAT_WAIT], 1'b1);
      chk("pause_idle", activityFlagOut, 1'b0);
      pulse(BEG);
      waitact(1'b1);
      pulse(STP);
      waitact(1'b0);
      @(posedge clock) pins.voiceTriggerSelect <= 1'b0;
      $display("test voice done");
   endtask
   task automatic t_host;
      av(1'b1, REG_CTRL, 32'h1);
      host.ceOff = 1'b1;
      host.fetch(v, oe);
      chk("ce_high_float", oe, 1'b1);
      host.ceOff = 1'b0;
      host.fetch(v, oe);
      chk("ce_low_drive", oe, 1'b0);
      // fixed mode channel 0 first, so the stop cannot disturb the index
      host.put(TRACK_CONFIG_CMD);
      host.put(4'h8);
      host.put(CAPTURE_VOICE_CMD);
      host.put(START_CMD);
      chk("host_start", activityFlagOut, 1'b1);
      host.put(STOP_CMD);
      chk("host_stop", activityFlagOut, 1'b0);
      host.put(TRACK_CONFIG_CMD);
      host.put(4'h0);
      host.put(INDEX_WRITE_CMD);
      for (int i = 0; i < 8; i++) host.put(IDX[4*i +: 4]);
      for (int c = 13; c < 16; c++) host.put(4'(c));
      host.put(IDLE_CODE);
      host.put(INDEX_READ_CMD);
      for (int i = 0; i < 8; i++) begin
         repeat (2100) @(posedge clock);
         host.fetch(v, oe);
         chk("index_nibble", v, IDX[4*i +: 4]);
      end
      host.put(VOICE_SELECT_CMD);
      host.put(4'h6);
      chk("voice_sel", {adpcmBitLength, voiceCondition}, 3'h6);
      $display("test host done");
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      pins = {3'b111, 1'b1, 1'b0, 1'b0, 2'b00, 3'h0, 1'b0};
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      repeat (40) @(posedge clock);
      t_avalon;
      t_rate;
      t_voice;
      t_host;
      wrap_up;
   end
   initial begin
      repeat (90000) @(posedge clock);
      fail_count++;
      wrap_up;
   end
endmodule // vrcs_top_tb
